// >>> hdl/tpl_latch.sv
// position latch channel two driven by the upper byte of the probe control word
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////
module tpl_latch
(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] control_i,
   input  wire logic        digital_input_trigger_i,
   input  wire logic        index_pulse_i,
   input  wire logic [31:0] position_i,
   output logic [31:0]      latched_pos_o,
   output logic             capture_o,
   output logic             captured_o,
   output logic             armed_o
);
   //////////////////////////////////////////////////////////////////////////////////////////
   logic                en;
   logic                cont;
   logic                src_idx;
   logic                rise_en;
   logic                fall_en;
   logic                dig_rise;
   logic                dig_fall;
   logic                ix_rise;
   logic                ix_fall;
   logic                trig_rise;
   logic                trig_fall;
   logic                event_hit;
   logic                take;
   logic                capture;
   logic [31:0]         latched_pos;
   logic                captured;
   tpl_pkg::tpl_state_t state;
   tpl_pkg::tpl_state_t next_state;

   // only the decoded bits are read, so unused bits cannot steer anything
   assign en      = control_i[tpl_pkg::BIT_ENABLE];
   assign cont    = control_i[tpl_pkg::BIT_CONTINUOUS];
   assign src_idx = control_i[tpl_pkg::BIT_SRC_INDEX];
   assign rise_en = control_i[tpl_pkg::BIT_RISE];
   assign fall_en = control_i[tpl_pkg::BIT_FALL];

   //////////////////////////////////////////////////////////////////////////////////////////
   // both inputs arrive from pins, hence synchronised before edge detection
   tpl_sync u_sync_dig
   (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .async_i (digital_input_trigger_i),
      .level_o (),
      .rise_o  (dig_rise),
      .fall_o  (dig_fall)
   );

   tpl_sync u_sync_ix
   (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .async_i (index_pulse_i),
      .level_o (),
      .rise_o  (ix_rise),
      .fall_o  (ix_fall)
   );

   assign trig_rise = src_idx ? ix_rise : dig_rise;
   assign trig_fall = src_idx ? ix_fall : dig_fall;
   assign event_hit = (rise_en & trig_rise) | (fall_en & trig_fall);
   assign take      = (state == tpl_pkg::TPL_ARMED) & event_hit;

   //////////////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = state;
      case (state)
         tpl_pkg::TPL_OFF:
            next_state = en ? tpl_pkg::TPL_ARMED : tpl_pkg::TPL_OFF;
         tpl_pkg::TPL_ARMED:
         begin
            if (!en)
               next_state = tpl_pkg::TPL_OFF;
            else if (take && !cont)
               next_state = tpl_pkg::TPL_DONE;
         end
         tpl_pkg::TPL_DONE:
         begin
            // switching to continuous re-arms; single mode waits for a disable
            if (!en)
               next_state = tpl_pkg::TPL_OFF;
            else if (cont)
               next_state = tpl_pkg::TPL_ARMED;
         end
         default:
            next_state = tpl_pkg::TPL_OFF;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state <= tpl_pkg::TPL_OFF;
      else
         state <= next_state;
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         latched_pos <= tpl_pkg::POS_RESET;
         capture     <= 1'b0;
      end
      else
      begin
         capture <= take & en;
         if (take && en)
            latched_pos <= position_i;
      end
   end

   // sticky capture flag, cleared when the channel is switched off
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         captured <= 1'b0;
      else if (take && en)
         captured <= 1'b1;
      else if (!en)
         captured <= 1'b0;
   end

   assign latched_pos_o = latched_pos;
   assign capture_o     = capture;
   assign captured_o    = captured;
   assign armed_o       = (state == tpl_pkg::TPL_ARMED);

   //////////////////////////////////////////////////////////////////////////////////////////
   property p_off_no_capture;
      @(posedge clock_i) disable iff (!rst_b_i)
      !$past(en) |-> !capture;
   endproperty
   a_off_no_capture: assert property (p_off_no_capture) else $error("capture while off");

   property p_single_once;
      @(posedge clock_i) disable iff (!rst_b_i)
      (take && en && !cont) |=> (state == tpl_pkg::TPL_DONE) || !$past(en);
   endproperty
   a_single_once: assert property (p_single_once) else $error("single mode not stopped");

   property p_cont_rearm;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_ARMED && en && cont) |=> (state == tpl_pkg::TPL_ARMED);
   endproperty
   a_cont_rearm: assert property (p_cont_rearm) else $error("continuous mode lost arm");

   property p_src_select;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_ARMED && en && rise_en && !fall_en && src_idx && ix_rise)
      |=> capture && latched_pos == $past(position_i);
   endproperty
   a_src_select: assert property (p_src_select) else $error("index edge missed");

   property p_rise_gate;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!rise_en && !(fall_en && trig_fall)) |=> !capture;
   endproperty
   a_rise_gate: assert property (p_rise_gate) else $error("rising edge not gated");

   property p_fall_gate;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!fall_en && !(rise_en && trig_rise)) |=> !capture;
   endproperty
   a_fall_gate: assert property (p_fall_gate) else $error("falling edge not gated");

   property p_fall_take;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_ARMED && en && fall_en && trig_fall) |=> capture;
   endproperty
   a_fall_take: assert property (p_fall_take) else $error("falling edge missed");

   property p_done_hold;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_DONE && en && !cont) |=> $stable(latched_pos);
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("latch changed after single");

   property p_enable_arms;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_OFF && en) |=> (state == tpl_pkg::TPL_ARMED);
   endproperty
   a_enable_arms: assert property (p_enable_arms) else $error("enable did not arm");

   property p_disable_clears;
      @(posedge clock_i) disable iff (!rst_b_i)
      !en |=> (state == tpl_pkg::TPL_OFF) && !captured;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("off not cleared");

   property p_rise_take;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_ARMED && en && rise_en && trig_rise)
      |=> capture && latched_pos == $past(position_i);
   endproperty
   a_rise_take: assert property (p_rise_take) else $error("rising edge missed");

   property p_done_quiet;
      @(posedge clock_i) disable iff (!rst_b_i)
      (state == tpl_pkg::TPL_DONE && !cont) |=> !capture;
   endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("capture after single");

   property p_src_ignore;
      @(posedge clock_i) disable iff (!rst_b_i)
      (src_idx && !ix_rise && !ix_fall) |=> !capture;
   endproperty
   a_src_ignore: assert property (p_src_ignore) else $error("other source captured");
endmodule

// >>> hdl/tpl_pkg.sv
// package: control word field positions and state encodings for latch channel two
package tpl_pkg;
   localparam int unsigned CTRL_W          = 16;
   localparam int unsigned POS_W           = 32;
   localparam int unsigned BIT_ENABLE      = 8;
   localparam int unsigned BIT_CONTINUOUS  = 9;
   localparam int unsigned BIT_SRC_INDEX   = 10;
   localparam int unsigned BIT_RISE        = 12;
   localparam int unsigned BIT_FALL        = 13;
   localparam logic [31:0] POS_RESET       = 32'h00000000;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   typedef enum logic [2:0]
   {
      TPL_OFF   = 3'b001,
      TPL_ARMED = 3'b010,
      TPL_DONE  = 3'b100
   } tpl_state_t;
endpackage

// >>> hdl/tpl_sync.sv
// two-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module tpl_sync
(
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= async_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level_o = sync;
   assign rise_o  = sync & ~prev;
   assign fall_o  = ~sync & prev;
endmodule

// >>> tb/tb.sv
// self-checking bench for latch channel two
`timescale 1ns/1ps
module tb;
   logic        clock_i;
   logic        rst_b_i;
   logic [15:0] want;
   logic        junk;
   logic [15:0] control;
   logic        dig_pin;
   logic        idx_pin;
   logic [31:0] position;
   logic [31:0] latched_pos;
   logic        capture;
   logic        captured;
   logic        armed;
   int          failures;
   int          comparisons;
   logic [31:0] expq [$];
   // each row: junk, control word, four steps of {valid, index, level, expect}
   logic [32:0] tbl [6];
   ////////////////////////////////////////////////////////////////////////////////
   tpl_host tpl_host_inst
   (
      .clock_i   (clock_i),
      .rst_b_i   (rst_b_i),
      .want_i    (want),
      .junk_i    (junk),
      .control_o (control)
   );
   tpl_latch tpl_latch_inst
   (
      .clock_i                 (clock_i),
      .rst_b_i                 (rst_b_i),
      .control_i               (control),
      .digital_input_trigger_i (dig_pin),
      .index_pulse_i           (idx_pin),
      .position_i              (position),
      .latched_pos_o           (latched_pos),
      .capture_o               (capture),
      .captured_o              (captured),
      .armed_o                 (armed)
   );
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // position is held for the whole step so the take cycle value is known
   task automatic step(input logic [3:0] s);
      logic [31:0] p;
      p = $urandom;
      @(posedge clock_i);
      position <= p;
      if (s[2])
         idx_pin <= s[1];
      else
         dig_pin <= s[1];
      if (s[0])
         expq.push_back(p);
      repeat (6) @(posedge clock_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock_i)
   begin
      if (capture === 1'b1)
      begin
         if (expq.size() == 0)
            check(32'h1, 32'h0);
         else
            check(latched_pos, expq.pop_front());
         check(captured, 1'b1);
      end
   end
   initial
   begin
      repeat (3000) @(posedge clock_i);
      failures++;
      final_report;
   end
   initial
   begin
      rst_b_i = 1'b0;
      want = 16'h0000;
      junk = 1'b0;
      dig_pin = 1'b0;
      idx_pin = 1'b0;
      position = 32'h00000000;
      failures = 0;
      comparisons = 0;
      tbl[0] = {1'b0, 16'h1100, 16'hB8A0};
      tbl[1] = {1'b0, 16'h3300, 16'hB9B9};
      tbl[2] = {1'b0, 16'h3700, 16'hA8FD};
      tbl[3] = {1'b0, 16'h3200, 16'hA800};
      tbl[4] = {1'b1, 16'h2100, 16'hA9A8};
      tbl[5] = {1'b0, 16'h1500, 16'hAFCE};
      void'($urandom(67500));
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      check(latched_pos, 32'h00000000);
      foreach (tbl[t])
      begin
         @(posedge clock_i);
         want <= 16'h0000;
         junk <= 1'b0;
         dig_pin <= 1'b0;
         idx_pin <= 1'b0;
         repeat (6) @(posedge clock_i);
         check({capture, captured, armed}, 32'h00000000);
         want <= tbl[t][31:16];
         junk <= tbl[t][32];
         repeat (4) @(posedge clock_i);
         check(armed, want[8]);
         for (int k = 3; k >= 0; k--)
         begin
            if (tbl[t][4*k+3])
               step(tbl[t][4*k +: 4]);
         end
         check(expq.size(), 0);
         $display("test %0d done", t);
      end
      final_report;
   end
endmodule

// >>> tb/tpl_host.sv
// host model that writes the probe control word
`timescale 1ns/1ps
module tpl_host
(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] want_i,
   input  wire logic        junk_i,
   output logic [15:0]      control_o
);
   // junk_i sets unused bits 15, 14, 11, 7 and 6 on purpose; otherwise those bits go out as zero
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         control_o <= tpl_pkg::CTRL_RESET;
      else if (junk_i)
         control_o <= want_i | 16'hC8C0;
      else
         control_o <= want_i & ~16'hC8C0;
   end
endmodule
